// File: core/pefm_mux.sv
// Purpose: pin function multiplexer for port E2-E6, F0-F3, G0-G2
// Assumes: APB slave, peripherals on ref_clk, pads asynchronous
// Notes:   every output registered; pad inputs pass two flops first
`timescale 1ns/1ps

module pefm_mux
	import pefm_pkg::*;
(
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// pads
	input  wire logic [NUM_PINS-1:0] pad_in,
	output logic      [NUM_PINS-1:0] pad_out,
	output logic      [NUM_PINS-1:0] pad_oe,
	// peripheral outputs towards pads
	input  wire logic                serial9_transmit,
	input  wire logic                serial9_clock_out,
	input  wire logic                serial9_clock_oe,
	input  wire logic                serial9_flow_select_out,
	input  wire logic                serial9_flow_select_oe,
	input  wire logic                serial11_transmit,
	input  wire logic                serial11_clock_out,
	input  wire logic                serial11_clock_oe,
	input  wire logic                serial11_flow_out,
	input  wire logic                serial11_flow_oe,
	input  wire logic                can_transmit_line,
	input  wire logic                eight_bit_timer_out_1,
	input  wire logic                comparator_out_0,
	input  wire logic                comparator_out_1,
	input  wire logic                comparator_out_2,
	input  wire logic                comparator_out_3,
	input  wire logic                pwm_timer0_io_a_out,
	input  wire logic                pwm_timer0_io_a_oe,
	input  wire logic                pwm_timer0_io_b_out,
	input  wire logic                pwm_timer0_io_b_oe,
	input  wire logic                pwm_timer1_io_b_out,
	input  wire logic                pwm_timer1_io_b_oe,
	// pad levels towards peripherals
	output logic                     output_disable_in_10_b,
	output logic                     output_disable_in_11_b,
	output logic                     timer_ext_clock_c,
	output logic                     timer_ext_clock_c_alt,
	output logic                     timer_ext_clock_d,
	output logic                     timer_ext_clock_d_alt,
	output logic                     pwm_timer_ext_trigger_a,
	output logic                     pwm_timer_ext_trigger_b,
	output logic                     pwm_timer_ext_trigger_c,
	output logic                     pwm_timer_ext_trigger_d,
	output logic                     serial9_receive,
	output logic                     serial9_clock_in,
	output logic                     serial9_flow_select_in,
	output logic                     serial11_receive,
	output logic                     serial11_clock_in,
	output logic                     serial11_flow_in,
	output logic                     can_receive_line,
	output logic                     pwm_timer0_io_a_in,
	output logic                     pwm_timer0_io_a_alt_in,
	output logic                     pwm_timer0_io_b_in,
	output logic                     pwm_timer0_io_b_alt_in,
	output logic                     pwm_timer1_io_b_in,
	output logic                     pwm_timer1_io_b_alt_in,
	// external interrupt inputs
	output logic      [NUM_PINS-1:0] pin_irq,
	output logic                     ext_irq_line_0,
	output logic                     ext_irq_line_1,
	output logic                     ext_irq_line_2,
	output logic                     ext_irq_line_3
);

	logic [7:0]          ctrl [NUM_PINS];
	logic [FSEL_W-1:0]   fsel [NUM_PINS];
	logic [NUM_PINS-1:0] irq_route_bit;
	logic [NUM_PINS-1:0] reg_hit;
	logic [7:0]          rd_terms [NUM_PINS];
	logic [NUM_PINS-1:0] pad_s;

	// apb decode
	wire access   = psel & penable;
	wire wr_en    = access & pwrite & pready & ~pslverr;
	wire any_hit  = |reg_hit;
	wire [7:0] rd_byte;

	genvar i;
	generate
		for (i = 0; i < NUM_PINS; i++) begin : g_reg
			assign reg_hit[i]       = (paddr == REG_OFFS[i]);
			assign fsel[i]          = ctrl[i][FSEL_LSB +: FSEL_W];
			assign irq_route_bit[i] = ctrl[i][IRQ_BIT];
			if (i == 0) begin : g_first
				assign rd_terms[i] = reg_hit[i] ? ctrl[i] : 8'h00;
			end else begin : g_rest
				assign rd_terms[i] = rd_terms[i-1] | (reg_hit[i] ? ctrl[i] : 8'h00);
			end
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					ctrl[i] <= CTRL_RESET;
				end else if (wr_en && reg_hit[i] && pstrb[0]) begin
					ctrl[i] <= pwdata[7:0] & CTRL_WMASK;
				end
			end
		end
	endgenerate

	assign rd_byte = rd_terms[NUM_PINS-1];

	// one wait state: pready rises the cycle after access begins
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~any_hit;
			prdata  <= (access & ~pready & ~pwrite & any_hit) ? {24'h00_0000, rd_byte}
			                                                 : 32'h0000_0000;
		end
	end

	// pad input synchroniser
	pefm_sync #(
		.W(NUM_PINS)
	) u_pad_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.async_in (pad_in),
		.sync_out (pad_s)
	);

	// selection matches
	wire e2_poe    = fsel[PIN_E2] == FSEL_POE;
	wire e3_clk    = fsel[PIN_E3] == FSEL_MTCLK;
	wire e3_clka   = fsel[PIN_E3] == FSEL_MTCLK_ALT;
	wire e3_poe    = fsel[PIN_E3] == FSEL_POE;
	wire e3_flow   = fsel[PIN_E3] == FSEL_SCI9;
	wire e4_clk    = fsel[PIN_E4] == FSEL_MTCLK;
	wire e4_clka   = fsel[PIN_E4] == FSEL_MTCLK_ALT;
	wire e4_poe    = fsel[PIN_E4] == FSEL_POE;
	wire e4_serial9_clock   = fsel[PIN_E4] == FSEL_SCI9;
	wire e6_poe    = fsel[PIN_E6] == FSEL_POE;
	wire f0_txd    = fsel[PIN_F0] == FSEL_SCI11;
	wire f0_tmr    = fsel[PIN_F0] == FSEL_TMR8;
	wire f0_trg    = fsel[PIN_F0] == FSEL_GPT_P0;
	wire f0_cmp    = fsel[PIN_F0] == FSEL_COMP;
	wire f1_rxd    = fsel[PIN_F1] == FSEL_SCI11;
	wire f1_trg    = fsel[PIN_F1] == FSEL_GPT_P0;
	wire f1_cmp    = fsel[PIN_F1] == FSEL_COMP;
	wire f2_sck    = fsel[PIN_F2] == FSEL_SCI11;
	wire f2_can    = fsel[PIN_F2] == FSEL_CAN;
	wire f2_trg    = fsel[PIN_F2] == FSEL_GPT_P0;
	wire f2_cmp    = fsel[PIN_F2] == FSEL_COMP;
	wire f3_flow   = fsel[PIN_F3] == FSEL_SCI11;
	wire f3_can    = fsel[PIN_F3] == FSEL_CAN;
	wire f3_trg    = fsel[PIN_F3] == FSEL_GPT_P0;
	wire f3_cmp    = fsel[PIN_F3] == FSEL_COMP;
	wire g0_rxd    = fsel[PIN_G0] == FSEL_SCI9;
	wire g0_io     = fsel[PIN_G0] == FSEL_GPT_P1;
	wire g0_ioa    = fsel[PIN_G0] == FSEL_GPT_P3;
	wire g0_cmp    = fsel[PIN_G0] == FSEL_COMP;
	wire g1_txd    = fsel[PIN_G1] == FSEL_SCI9;
	wire g1_io     = fsel[PIN_G1] == FSEL_GPT_P1;
	wire g1_ioa    = fsel[PIN_G1] == FSEL_GPT_P3;
	wire g1_cmp    = fsel[PIN_G1] == FSEL_COMP;
	wire g2_sck    = fsel[PIN_G2] == FSEL_SCI9;
	wire g2_trg    = fsel[PIN_G2] == FSEL_GPT_P0;
	wire g2_io     = fsel[PIN_G2] == FSEL_GPT_P1;
	wire g2_ioa    = fsel[PIN_G2] == FSEL_GPT_P3;
	wire g2_cmp    = fsel[PIN_G2] == FSEL_COMP;

	// trigger slot k on E3/E4/E6 drives trigger a..d
	logic [3:0] etrg_e3;
	logic [3:0] etrg_e4;
	logic [3:0] etrg_e6;
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_trg
			localparam logic [FSEL_W-1:0] CODE = FSEL_GPT_P0 + FSEL_W'(k);
			assign etrg_e3[k] = (fsel[PIN_E3] == CODE) & pad_s[PIN_E3];
			assign etrg_e4[k] = (fsel[PIN_E4] == CODE) & pad_s[PIN_E4];
			assign etrg_e6[k] = (fsel[PIN_E6] == CODE) & pad_s[PIN_E6];
		end
	endgenerate
	wire [3:0] etrg_any = etrg_e3 | etrg_e4 | etrg_e6;

	// pad drive, unlisted codes fall to 0/off
	wire [NUM_PINS-1:0] next_pad_out;
	wire [NUM_PINS-1:0] next_pad_oe;

	assign next_pad_out[PIN_E2] = 1'b0;
	assign next_pad_oe[PIN_E2]  = 1'b0;
	assign next_pad_out[PIN_E3] = e3_flow & serial9_flow_select_out;
	assign next_pad_oe[PIN_E3]  = e3_flow & serial9_flow_select_oe;
	assign next_pad_out[PIN_E4] = e4_serial9_clock & serial9_clock_out;
	assign next_pad_oe[PIN_E4]  = e4_serial9_clock & serial9_clock_oe;
	assign next_pad_out[PIN_E5] = 1'b0;
	assign next_pad_oe[PIN_E5]  = 1'b0;
	assign next_pad_out[PIN_E6] = 1'b0;
	assign next_pad_oe[PIN_E6]  = 1'b0;
	assign next_pad_out[PIN_F0] = (f0_txd & serial11_transmit) | (f0_tmr & eight_bit_timer_out_1)
	                            | (f0_cmp & comparator_out_3);
	assign next_pad_oe[PIN_F0]  = f0_txd | f0_tmr | f0_cmp;
	assign next_pad_out[PIN_F1] = f1_cmp & comparator_out_2;
	assign next_pad_oe[PIN_F1]  = f1_cmp;
	assign next_pad_out[PIN_F2] = (f2_sck & serial11_clock_out) | (f2_can & can_transmit_line)
	                            | (f2_cmp & comparator_out_1);
	assign next_pad_oe[PIN_F2]  = (f2_sck & serial11_clock_oe) | f2_can | f2_cmp;
	assign next_pad_out[PIN_F3] = (f3_flow & serial11_flow_out) | (f3_cmp & comparator_out_0);
	assign next_pad_oe[PIN_F3]  = (f3_flow & serial11_flow_oe) | f3_cmp;
	assign next_pad_out[PIN_G0] = ((g0_io | g0_ioa) & pwm_timer1_io_b_out)
	                            | (g0_cmp & comparator_out_2);
	assign next_pad_oe[PIN_G0]  = ((g0_io | g0_ioa) & pwm_timer1_io_b_oe) | g0_cmp;
	assign next_pad_out[PIN_G1] = (g1_txd & serial9_transmit) | ((g1_io | g1_ioa) & pwm_timer0_io_a_out)
	                            | (g1_cmp & comparator_out_1);
	assign next_pad_oe[PIN_G1]  = g1_txd | ((g1_io | g1_ioa) & pwm_timer0_io_a_oe) | g1_cmp;
	assign next_pad_out[PIN_G2] = (g2_sck & serial9_clock_out) | ((g2_io | g2_ioa) & pwm_timer0_io_b_out)
	                            | (g2_cmp & comparator_out_0);
	assign next_pad_oe[PIN_G2]  = (g2_sck & serial9_clock_oe) | ((g2_io | g2_ioa) & pwm_timer0_io_b_oe)
	                            | g2_cmp;

	// peripheral inputs, idle levels when unrouted
	wire next_od10_b  = ~((e2_poe & ~pad_s[PIN_E2]) | (e4_poe & ~pad_s[PIN_E4])
	                    | (e6_poe & ~pad_s[PIN_E6]));
	wire next_od11_b  = ~(e3_poe & ~pad_s[PIN_E3]);
	wire next_trg_a   = etrg_any[0] | (f3_trg & pad_s[PIN_F3]) | (g2_trg & pad_s[PIN_G2]);
	wire next_trg_b   = etrg_any[1] | (f2_trg & pad_s[PIN_F2]);
	wire next_trg_c   = etrg_any[2] | (f1_trg & pad_s[PIN_F1]);
	wire next_trg_d   = etrg_any[3] | (f0_trg & pad_s[PIN_F0]);
	wire next_serial9_clock_in = e4_serial9_clock ? pad_s[PIN_E4] : (g2_sck ? pad_s[PIN_G2] : 1'b1);
	wire next_flow9   = e3_flow ? pad_s[PIN_E3] : 1'b1;
	wire next_rxd9    = g0_rxd ? pad_s[PIN_G0] : 1'b1;
	wire next_serial11_receive   = f1_rxd ? pad_s[PIN_F1] : 1'b1;
	wire next_serial11_clock   = f2_sck ? pad_s[PIN_F2] : 1'b1;
	wire next_flow11  = f3_flow ? pad_s[PIN_F3] : 1'b1;
	wire next_crx     = f3_can ? pad_s[PIN_F3] : 1'b1;
	wire [NUM_PINS-1:0] next_pin_irq = irq_route_bit & pad_s;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pad_out <= '0;
			pad_oe  <= '0;
			pin_irq <= '0;
		end else begin
			pad_out <= next_pad_out;
			pad_oe  <= next_pad_oe;
			pin_irq <= next_pin_irq;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			output_disable_in_10_b  <= 1'b1;
			output_disable_in_11_b  <= 1'b1;
			timer_ext_clock_c       <= 1'b0;
			timer_ext_clock_c_alt   <= 1'b0;
			timer_ext_clock_d       <= 1'b0;
			timer_ext_clock_d_alt   <= 1'b0;
			pwm_timer_ext_trigger_a <= 1'b0;
			pwm_timer_ext_trigger_b <= 1'b0;
			pwm_timer_ext_trigger_c <= 1'b0;
			pwm_timer_ext_trigger_d <= 1'b0;
		end else begin
			output_disable_in_10_b  <= next_od10_b;
			output_disable_in_11_b  <= next_od11_b;
			timer_ext_clock_c       <= e4_clk & pad_s[PIN_E4];
			timer_ext_clock_c_alt   <= e4_clka & pad_s[PIN_E4];
			timer_ext_clock_d       <= e3_clk & pad_s[PIN_E3];
			timer_ext_clock_d_alt   <= e3_clka & pad_s[PIN_E3];
			pwm_timer_ext_trigger_a <= next_trg_a;
			pwm_timer_ext_trigger_b <= next_trg_b;
			pwm_timer_ext_trigger_c <= next_trg_c;
			pwm_timer_ext_trigger_d <= next_trg_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			serial9_receive        <= 1'b1;
			serial9_clock_in       <= 1'b1;
			serial9_flow_select_in <= 1'b1;
			serial11_receive       <= 1'b1;
			serial11_clock_in      <= 1'b1;
			serial11_flow_in       <= 1'b1;
			can_receive_line       <= 1'b1;
		end else begin
			serial9_receive        <= next_rxd9;
			serial9_clock_in       <= next_serial9_clock_in;
			serial9_flow_select_in <= next_flow9;
			serial11_receive       <= next_serial11_receive;
			serial11_clock_in      <= next_serial11_clock;
			serial11_flow_in       <= next_flow11;
			can_receive_line       <= next_crx;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwm_timer0_io_a_in     <= 1'b0;
			pwm_timer0_io_a_alt_in <= 1'b0;
			pwm_timer0_io_b_in     <= 1'b0;
			pwm_timer0_io_b_alt_in <= 1'b0;
			pwm_timer1_io_b_in     <= 1'b0;
			pwm_timer1_io_b_alt_in <= 1'b0;
			ext_irq_line_0         <= 1'b0;
			ext_irq_line_1         <= 1'b0;
			ext_irq_line_2         <= 1'b0;
			ext_irq_line_3         <= 1'b0;
		end else begin
			pwm_timer0_io_a_in     <= g1_io & pad_s[PIN_G1];
			pwm_timer0_io_a_alt_in <= g1_ioa & pad_s[PIN_G1];
			pwm_timer0_io_b_in     <= g2_io & pad_s[PIN_G2];
			pwm_timer0_io_b_alt_in <= g2_ioa & pad_s[PIN_G2];
			pwm_timer1_io_b_in     <= g0_io & pad_s[PIN_G0];
			pwm_timer1_io_b_alt_in <= g0_ioa & pad_s[PIN_G0];
			ext_irq_line_0         <= next_pin_irq[PIN_E5];
			ext_irq_line_1         <= next_pin_irq[PIN_E4];
			ext_irq_line_2         <= next_pin_irq[PIN_E3];
			ext_irq_line_3         <= next_pin_irq[PIN_E6];
		end
	end

endmodule

// File: core/pefm_pkg.sv
// Purpose: shared constants for the port E/F/G pin function multiplexer
// Assumes: APB slave with 8-bit byte address, one 32-bit word per pin register
// Notes:   control register = {reserved, interrupt route bit, 6-bit function select}
package pefm_pkg;

	localparam int NUM_PINS = 12;
	localparam int ADDR_W   = 8;

	// pin slots, in register order
	localparam int PIN_E2 = 0;
	localparam int PIN_E3 = 1;
	localparam int PIN_E4 = 2;
	localparam int PIN_E5 = 3;
	localparam int PIN_E6 = 4;
	localparam int PIN_F0 = 5;
	localparam int PIN_F1 = 6;
	localparam int PIN_F2 = 7;
	localparam int PIN_F3 = 8;
	localparam int PIN_G0 = 9;
	localparam int PIN_G1 = 10;
	localparam int PIN_G2 = 11;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_E2_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_E3_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_E4_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_E5_CTRL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_E6_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_F0_CTRL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_F1_CTRL = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_F2_CTRL = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_F3_CTRL = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_G0_CTRL = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_G1_CTRL = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_G2_CTRL = 8'h2C;

	localparam logic [ADDR_W-1:0] REG_OFFS [NUM_PINS] = '{
		OFF_E2_CTRL, OFF_E3_CTRL, OFF_E4_CTRL, OFF_E5_CTRL, OFF_E6_CTRL, OFF_F0_CTRL,
		OFF_F1_CTRL, OFF_F2_CTRL, OFF_F3_CTRL, OFF_G0_CTRL, OFF_G1_CTRL, OFF_G2_CTRL
	};

	// control register layout
	localparam int FSEL_LSB = 0;
	localparam int FSEL_W   = 6;
	localparam int IRQ_BIT  = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h7F;

	// function select codes
	localparam logic [FSEL_W-1:0] FSEL_HIZ       = 6'h00;
	localparam logic [FSEL_W-1:0] FSEL_MTCLK     = 6'h02;
	localparam logic [FSEL_W-1:0] FSEL_MTCLK_ALT = 6'h04;
	localparam logic [FSEL_W-1:0] FSEL_TMR8      = 6'h05;
	localparam logic [FSEL_W-1:0] FSEL_POE       = 6'h07;
	localparam logic [FSEL_W-1:0] FSEL_SCI9      = 6'h0A;
	localparam logic [FSEL_W-1:0] FSEL_SCI11     = 6'h0B;
	localparam logic [FSEL_W-1:0] FSEL_CAN       = 6'h10;
	// pwm timer group slots: triggers a..d, or timer io and its alternate
	localparam logic [FSEL_W-1:0] FSEL_GPT_P0    = 6'h14;
	localparam logic [FSEL_W-1:0] FSEL_GPT_P1    = 6'h15;
	localparam logic [FSEL_W-1:0] FSEL_GPT_P2    = 6'h16;
	localparam logic [FSEL_W-1:0] FSEL_GPT_P3    = 6'h17;
	localparam logic [FSEL_W-1:0] FSEL_COMP      = 6'h1E;

endpackage

// File: core/pefm_sync.sv
// Purpose: two-stage level synchroniser for pad inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds the second stage only
`timescale 1ns/1ps
module pefm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	// data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage1;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// File: sim/pefm_mux_properties.sv
// Purpose: concurrent checks on the pin function multiplexer ports
// Assumes: one clock domain, async active-low reset, register shadow kept here
// Notes:   bound to pefm_mux below the module
`timescale 1ns/1ps
module pefm_mux_properties
	import pefm_pkg::*;
(
	// clock and reset
	input wire logic                ref_clk,
	input wire logic                rst_b,
	// apb
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [ADDR_W-1:0]   paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [3:0]          pstrb,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// pads and routed signals
	input wire logic [NUM_PINS-1:0] pad_in,
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe,
	input wire logic                can_transmit_line,
	input wire logic                output_disable_in_10_b,
	input wire logic [NUM_PINS-1:0] pin_irq,
	input wire logic                ext_irq_line_0
);
	logic [6:0] sh [NUM_PINS];
	wire logic  wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// shadow of the control registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				sh[i] <= 7'h00;
			end
		end else if (wr_ok) begin
			sh[paddr[7:2]] <= pwdata[6:0];
		end
	end

	ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	addr_err_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h2C))
		else $error("error response wrong for address");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero outside answer");
	rdata_reg_a: assert property (pready && !pwrite && !pslverr |-> prdata == {25'h0, sh[paddr[7:2]]})
		else $error("read data differs from written value");
	line_zero_a: assert property (ext_irq_line_0 == ($past(pad_in[3], 3) && $past(sh[3][6])))
		else $error("interrupt line 0 wrong");
	disable_ten_a: assert property (output_disable_in_10_b == !(
		($past(sh[0][5:0]) == 6'h07 && !$past(pad_in[0], 3)) ||
		($past(sh[2][5:0]) == 6'h07 && !$past(pad_in[2], 3)) ||
		($past(sh[4][5:0]) == 6'h07 && !$past(pad_in[4], 3))))
		else $error("output disable 10 wrong");
	can_drive_a: assert property ($past(sh[7][5:0]) == 6'h10 |->
		pad_out[7] == $past(can_transmit_line) && pad_oe[7])
		else $error("can transmit not on pad");

	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		hiz_pin_a: assert property ($past(sh[i][5:0]) == 6'h00 |-> !pad_oe[i])
			else $error("pad driven with no function");
		irq_pin_a: assert property (pin_irq[i] == ($past(pad_in[i], 3) && $past(sh[i][6])))
			else $error("pin interrupt wrong");
	end

	cover property (pready && pslverr);
	cover property (!output_disable_in_10_b);
	cover property (ext_irq_line_0);
endmodule

bind pefm_mux pefm_mux_properties u_props (
	.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
	.can_transmit_line(can_transmit_line), .output_disable_in_10_b(output_disable_in_10_b),
	.pin_irq(pin_irq), .ext_irq_line_0(ext_irq_line_0)
);

// File: sim/pefm_mux_bench.sv
// Purpose: self-checking bench for the pin function multiplexer
// Assumes: apb answers with one wait state, pads routed after a few edges
// Notes:   bus results queued by the driver and compared by the monitor
`timescale 1ns/1ps
module pefm_mux_bench
	import pefm_pkg::*;
;
	// {pin, code, observed output index}
	localparam logic [19:0] IN_T [35] = '{20'h0_07_00, 20'h1_02_04, 20'h1_04_05, 20'h1_07_01,
		20'h1_0A_0C, 20'h1_14_06, 20'h1_15_07, 20'h1_17_09, 20'h2_02_02, 20'h2_04_03, 20'h2_07_00,
		20'h2_0A_0B, 20'h2_16_08, 20'h4_07_00, 20'h4_14_06, 20'h4_15_07, 20'h4_16_08, 20'h4_17_09,
		20'h5_14_09, 20'h6_0B_0D, 20'h6_14_08, 20'h7_14_07, 20'h8_10_0E, 20'h8_14_06, 20'h9_0A_0A,
		20'hB_14_06, 20'h7_0B_0F, 20'h8_0B_10, 20'hA_15_11, 20'hA_17_12, 20'hB_15_13, 20'hB_17_14,
		20'h9_15_15, 20'h9_17_16, 20'hB_0A_0B};
	// {pin, code, source index, enable index}; index 16h is always on
	localparam logic [27:0] OUT_T [22] = '{28'h5_0B_05_16, 28'h5_05_0B_16, 28'h5_1E_0F_16,
		28'h6_1E_0E_16, 28'h7_0B_06_07, 28'h7_10_0A_16, 28'h7_1E_0D_16, 28'h8_0B_08_09,
		28'h8_1E_0C_16, 28'h9_15_14_15, 28'h9_17_14_15, 28'h9_1E_0E_16, 28'hA_0A_00_16,
		28'hA_15_10_11, 28'hA_17_10_11, 28'hA_1E_0D_16, 28'hB_0A_01_02, 28'hB_15_12_13,
		28'hB_17_12_13, 28'hB_1E_0C_16, 28'h1_0A_03_04, 28'h2_0A_01_02};
	localparam logic [22:0] IDLE = 23'h01FC03;

	logic        ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [11:0] pad_in = 12'hFFF;
	logic [21:0] per = 22'h0;
	logic [32:0] exp_q [$];
	int          n_errors = 0, cmp_count = 0;
	wire logic [31:0] prdata;
	wire logic [11:0] pad_out, pad_oe, pin_irq;
	wire logic pready, pslverr, output_disable_in_10_b, output_disable_in_11_b, timer_ext_clock_c,
		timer_ext_clock_c_alt, timer_ext_clock_d, timer_ext_clock_d_alt, pwm_timer_ext_trigger_a,
		pwm_timer_ext_trigger_b, pwm_timer_ext_trigger_c, pwm_timer_ext_trigger_d, serial9_receive,
		serial9_clock_in, serial9_flow_select_in, serial11_receive, serial11_clock_in,
		serial11_flow_in, can_receive_line, pwm_timer0_io_a_in, pwm_timer0_io_a_alt_in,
		pwm_timer0_io_b_in, pwm_timer0_io_b_alt_in, pwm_timer1_io_b_in, pwm_timer1_io_b_alt_in,
		ext_irq_line_0, ext_irq_line_1, ext_irq_line_2, ext_irq_line_3, serial9_transmit,
		serial9_clock_out, serial9_clock_oe, serial9_flow_select_out, serial9_flow_select_oe,
		serial11_transmit, serial11_clock_out, serial11_clock_oe, serial11_flow_out,
		serial11_flow_oe, can_transmit_line, eight_bit_timer_out_1, comparator_out_0,
		comparator_out_1, comparator_out_2, comparator_out_3, pwm_timer0_io_a_out,
		pwm_timer0_io_a_oe, pwm_timer0_io_b_out, pwm_timer0_io_b_oe, pwm_timer1_io_b_out,
		pwm_timer1_io_b_oe;
	wire logic [22:0] px = {1'b1, per};
	wire logic [3:0]  eirq = {ext_irq_line_3, ext_irq_line_2, ext_irq_line_1, ext_irq_line_0};
	wire logic [22:0] obs = {pwm_timer1_io_b_alt_in, pwm_timer1_io_b_in, pwm_timer0_io_b_alt_in,
		pwm_timer0_io_b_in, pwm_timer0_io_a_alt_in, pwm_timer0_io_a_in, serial11_flow_in,
		serial11_clock_in, can_receive_line, serial11_receive, serial9_flow_select_in,
		serial9_clock_in, serial9_receive, pwm_timer_ext_trigger_d, pwm_timer_ext_trigger_c,
		pwm_timer_ext_trigger_b, pwm_timer_ext_trigger_a, timer_ext_clock_d_alt, timer_ext_clock_d,
		timer_ext_clock_c_alt, timer_ext_clock_c, output_disable_in_11_b, output_disable_in_10_b};

	assign {pwm_timer1_io_b_oe, pwm_timer1_io_b_out, pwm_timer0_io_b_oe, pwm_timer0_io_b_out,
		pwm_timer0_io_a_oe, pwm_timer0_io_a_out, comparator_out_3, comparator_out_2,
		comparator_out_1, comparator_out_0, eight_bit_timer_out_1, can_transmit_line,
		serial11_flow_oe, serial11_flow_out, serial11_clock_oe, serial11_clock_out,
		serial11_transmit, serial9_flow_select_oe, serial9_flow_select_out, serial9_clock_oe,
		serial9_clock_out, serial9_transmit} = per;

	pefm_mux u_dut (.*);

	always #2 ref_clk = ~ref_clk;

	task conclude;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task cmp_bus(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: bus got %h expected %h", $time, got, exp);
		end
	endtask

	task cmp_pin(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: level got %b expected %b", $time, got, exp);
		end
	endtask

	// driver side: setup, access, hold until ready
	task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int k;
		exp_q.push_back(e);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input int p, input logic [6:0] v);
		apb(1'b1, REG_OFFS[p], {25'h0, v}, 33'h0);
	endtask

	task settle;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask

	// monitor side: each answer against the oldest note
	always @(posedge ref_clk) begin
		if (pready === 1'b1) begin
			cmp_bus({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'hx);
		end
	end

	initial begin
		int p, k, j, o;
		logic [31:0] vals [12];
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		void'($urandom(86));
		for (p = 0; p < 12; p++) begin
			apb(1'b0, REG_OFFS[p], 32'h0, 33'h0);
			vals[p] = $urandom;
			apb(1'b1, REG_OFFS[p], vals[p], 33'h0);
		end
		for (p = 0; p < 12; p++) begin
			apb(1'b0, REG_OFFS[p], 32'h0, {26'h0, vals[p][6:0]});
		end
		apb(1'b1, 8'h30, 32'hFF, {1'b1, 32'h0});
		apb(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0});
		@(posedge ref_clk) pstrb <= 4'h0;
		wr(0, ~vals[0][6:0]);
		pstrb <= 4'hF;
		apb(1'b0, REG_OFFS[0], 32'h0, {26'h0, vals[0][6:0]});
		for (p = 0; p < 12; p++) begin
			wr(p, 7'h00);
		end
		for (int t = 0; t < 35; t++) begin
			p = IN_T[t][19:16];
			k = IN_T[t][4:0];
			wr(p, {1'b0, IN_T[t][13:8]});
			for (int v = 0; v < 2; v++) begin
				@(posedge ref_clk) pad_in[p] <= v[0];
				settle();
				cmp_pin(obs[k], v[0]);
			end
			wr(p, 7'h00);
			@(posedge ref_clk) pad_in[p] <= ~IDLE[k];
			settle();
			cmp_pin(obs[k], IDLE[k]);
			cmp_pin(pad_oe[p], 1'b0);
			@(posedge ref_clk) pad_in[p] <= 1'b1;
		end
		for (int t = 0; t < 22; t++) begin
			p = OUT_T[t][27:24];
			j = OUT_T[t][12:8];
			o = OUT_T[t][4:0];
			wr(p, {1'b0, OUT_T[t][21:16]});
			repeat (4) begin
				@(posedge ref_clk) per <= 22'($urandom);
				repeat (2) @(posedge ref_clk);
				#1;
				cmp_pin(pad_out[p], px[j]);
				cmp_pin(pad_oe[p], px[o]);
			end
			wr(p, 7'h3F);
			settle();
			cmp_pin(pad_oe[p] | pad_out[p], 1'b0);
		end
		for (p = 0; p < 12; p++) begin
			wr(p, 7'h47);
			for (int v = 0; v < 2; v++) begin
				@(posedge ref_clk) pad_in[p] <= v[0];
				settle();
				cmp_pin(pin_irq[p], v[0]);
				cmp_bus({29'h0, eirq}, {29'h0, {p == 4, p == 1, p == 2, p == 3} & {4{v[0]}}});
				if (p == 3) begin
					cmp_pin(output_disable_in_10_b, 1'b1);
					cmp_pin(pad_oe[3], 1'b0);
				end
			end
			wr(p, 7'h00);
			settle();
			cmp_pin(pin_irq[p], 1'b0);
		end
		conclude();
	end
endmodule
